//--- hw/isic_ctrl.sv
// interrupt acceptance, standby and system instruction control
`default_nettype none
module isic_ctrl
  import isic_pkg::*;
#(
  parameter int          NSRC  = 4,
  parameter int          SYSW  = 4,
  parameter int          DEPTH = 8,
  parameter logic [15:0] VBASE = VEC_BASE
) (
  input  wire logic            i_mclk,
  input  wire logic            i_rst_n,
  // apb slave
  input  wire logic            i_psel,
  input  wire logic            i_penable,
  input  wire logic            i_pwrite,
  input  wire logic [7:0]      i_paddr,
  input  wire logic [31:0]     i_pwdata,
  output logic [31:0]          o_prdata,
  output logic                 o_pready,
  output logic                 o_pslverr,
  // core side
  input  wire logic            i_instr_valid,
  input  wire logic [15:0]     i_instr,
  input  wire logic [15:0]     i_ret_addr,
  input  wire logic [15:0]     i_stack_top,
  input  wire logic [SYSW-1:0] i_sys_state,
  input  wire logic [NSRC-1:0] i_src_req,
  input  wire logic [3:0]      i_wake,
  output logic                 o_hold,
  output logic                 o_pc_load,
  output logic [15:0]          o_pc_addr,
  output logic                 o_pc_inc,
  output logic                 o_sp_dec,
  output logic                 o_sp_inc,
  output logic                 o_stack_wr,
  output logic [15:0]          o_stack_wdata,
  output logic                 o_sys_restore,
  output logic [SYSW-1:0]      o_sys_data,
  output logic                 o_osc_en,
  output logic                 o_irq
);
  // ==========================================================
  // decode
  logic ex_on;
  logic ex_off;
  logic ex_stop;
  logic ex_halt;
  logic ex_idle;
  logic ex_return_from_irq_instr;
  assign ex_on   = i_instr_valid && is_sys(i_instr, SUB_ON, FLD_CTL, 1'b0);
  assign ex_off  = i_instr_valid && is_sys(i_instr, SUB_OFF, FLD_CTL, 1'b0);
  assign ex_stop = i_instr_valid && is_sys(i_instr, SUB_STOP, FLD_CTL, 1'b1);
  assign ex_halt = i_instr_valid && is_sys(i_instr, SUB_HALT, FLD_CTL, 1'b1);
  assign ex_idle = i_instr_valid && is_sys(i_instr, SUB_IDLE, FLD_CTL, 1'b0);
  assign ex_return_from_irq_instr = i_instr_valid && is_sys(i_instr, SUB_IDLE, FLD_RET, 1'b0);

  // ==========================================================
  // state
  isic_state_t     state;
  isic_state_t     next_state;
  logic            gie;
  logic            shadow;
  logic [3:0]      wake_sel;
  logic [NSRC-1:0] permit;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] pick;
  logic            any_ready;
  logic            want;
  logic            woke;
  logic            take;
  logic [EVTW-1:0] evt;
  logic [EVTW-1:0] mask;
  logic [EVTW-1:0] evt_set;

  // shadow blocks acceptance for one instruction
  assign want = gie && !shadow && any_ready;
  assign take = (state == ST_RUN) && want;
  // operand bits pick the restart causes
  // operand bits pick the release causes
  assign woke = |(i_wake & wake_sel);
  // core may issue only while this is low
  assign o_hold = (state != ST_RUN) || want;

  // ==========================================================
  isic_src_flags #(
    .NSRC (NSRC)
  ) u_flags (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_src_req (i_src_req),
    .i_permit  (permit),
    .i_take    (take),
    .o_pend    (pend),
    .o_any     (any_ready),
    .o_pick    (pick)
  );

  // system state saved at acceptance, restored at return
  isic_ctx_stack #(
    .SYSW  (SYSW),
    .DEPTH (DEPTH)
  ) u_ctx (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_push  (take),
    .i_pop   (ex_return_from_irq_instr),
    .i_data  (i_sys_state),
    .o_data  (o_sys_data)
  );

  // ==========================================================
  function automatic logic [15:0] vec_of(input logic [NSRC-1:0] oh);
    vec_of = VBASE;
    for (int k = 0; k < NSRC; k++) begin
      if (oh[k]) begin
        vec_of = VBASE + 16'(k);
      end
    end
  endfunction : vec_of

  // ==========================================================
  // mode sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (take) begin
          next_state = ST_ACPT;
        end else if (ex_stop) begin
          next_state = ST_STOP;
        end else if (ex_halt) begin
          next_state = ST_HALT;
        end
      end
      ST_ACPT: begin
        next_state = ST_RUN;
      end
      ST_HALT: begin
        if (woke) begin
          next_state = ST_RUN;
        end
      end
      ST_STOP: begin
        if (woke) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // release condition latched from the operand
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wake_sel <= 4'h0;
    end else if (state == ST_RUN && !take && (ex_stop || ex_halt)) begin
      wake_sel <= i_instr[3:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_osc_en <= 1'b1;
    end else begin
      o_osc_en <= (next_state != ST_STOP);
    end
  end

  // ==========================================================
  // global enable and one-instruction shadow
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      gie    <= RST_GIE;
      shadow <= 1'b0;
    end else begin
      if (ex_on) begin
        gie    <= 1'b1;
        shadow <= 1'b1;
      end else if (ex_off) begin
        gie <= 1'b0;
      end else if (take) begin
        // nesting needs a fresh enable in the handler
        gie <= 1'b0;
      end
      // shadow ends when the following instruction completes
      if (i_instr_valid && !ex_on) begin
        shadow <= 1'b0;
      end
    end
  end

  // ==========================================================
  // core strobes, one cycle after the deciding edge
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_pc_load     <= 1'b0;
      o_pc_addr     <= 16'h0000;
      o_pc_inc      <= 1'b0;
      o_sp_dec      <= 1'b0;
      o_sp_inc      <= 1'b0;
      o_stack_wr    <= 1'b0;
      o_stack_wdata <= 16'h0000;
      o_sys_restore <= 1'b0;
    end else begin
      o_pc_load     <= 1'b0;
      o_pc_inc      <= 1'b0;
      o_sp_dec      <= 1'b0;
      o_sp_inc      <= 1'b0;
      o_stack_wr    <= 1'b0;
      o_sys_restore <= 1'b0;
      if (take) begin
        o_sp_dec      <= 1'b1;
        o_stack_wr    <= 1'b1;
        o_stack_wdata <= i_ret_addr;
        o_pc_load     <= 1'b1;
        o_pc_addr     <= vec_of(pick);
      end else if (ex_return_from_irq_instr) begin
        // pc from stack top, sp up
        o_pc_load     <= 1'b1;
        o_pc_addr     <= i_stack_top;
        o_sp_inc      <= 1'b1;
        o_sys_restore <= 1'b1;
      end else if (ex_idle) begin
        o_pc_inc <= 1'b1;
      end
    end
  end

  // ==========================================================
  // events
  always_comb begin
    evt_set           = '0;
    evt_set[EVT_ACPT] = take;
    evt_set[EVT_HALT] = (state == ST_RUN) && !take && ex_halt;
    evt_set[EVT_STOP] = (state == ST_RUN) && !take && ex_stop;
    evt_set[EVT_WAKE] = (state == ST_HALT || state == ST_STOP) && woke;
  end

  // ==========================================================
  // apb: no wait states, unmapped addresses flag an error
  logic rd_acc;
  logic wr_acc;
  logic mapped;
  assign o_pready = 1'b1;
  assign rd_acc   = i_psel && i_penable && !i_pwrite;
  assign wr_acc   = i_psel && i_penable && i_pwrite;
  assign mapped   = (i_paddr == OFS_PERMIT) || (i_paddr == OFS_PEND) ||
                    (i_paddr == OFS_STATE) || (i_paddr == OFS_EVT) ||
                    (i_paddr == OFS_MASK);
  assign o_pslverr = i_psel && i_penable && !mapped;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      permit <= '0;
      mask   <= RST_MASK;
    end else if (wr_acc) begin
      // setting a permit releases a held request
      if (i_paddr == OFS_PERMIT) begin
        permit <= i_pwdata[NSRC-1:0];
      end
      if (i_paddr == OFS_MASK) begin
        mask <= i_pwdata[EVTW-1:0];
      end
    end
  end

  // read clears the status; a same-cycle event survives
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      evt <= RST_EVT;
    end else begin
      evt <= ((rd_acc && i_paddr == OFS_EVT) ? '0 : evt) | evt_set;
    end
  end

  always_comb begin
    o_prdata = 32'h0000_0000;
    if (rd_acc) begin
      unique case (i_paddr)
        OFS_PERMIT: o_prdata[NSRC-1:0] = permit;
        OFS_PEND:   o_prdata[NSRC-1:0] = pend;
        OFS_STATE: begin
          o_prdata[BIT_GIE]    = gie;
          o_prdata[BIT_SHADOW] = shadow;
          o_prdata[BIT_HALT]   = (state == ST_HALT);
          o_prdata[BIT_STOP]   = (state == ST_STOP);
        end
        OFS_EVT:    o_prdata[EVTW-1:0] = evt;
        OFS_MASK:   o_prdata[EVTW-1:0] = mask;
        default:    o_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |((((rd_acc && i_paddr == OFS_EVT) ? '0 : evt) | evt_set) & mask);
    end
  end
endmodule : isic_ctrl
`default_nettype wire

//--- hw/isic_pkg.sv
// constants shared by the interrupt, standby and system-instruction control
// Function
// - interrupt enable opcode decoded and turns on acceptance
// - no acceptance until next instruction completes
// - pending request vectored after that instruction
// - clear permit flag blocks diversion
// - request flag still set; taken once permitted
// - interrupt disable opcode turns off acceptance
// - clock stop opcode halts oscillator
// - clock stop operand selects restart condition
// - halt opcode suspends instruction execution
// - halt operand selects release condition
// - idle opcode uses one cycle, advances pc
// - interrupt return restores saved system state
// - interrupt return loads pc, increments stack pointer
`default_nettype none
package isic_pkg;
  // ==========================================================
  // instruction fields
  localparam logic [4:0] GRP_SYS  = 5'h07;
  localparam logic [2:0] SUB_ON   = 3'h0;
  localparam logic [2:0] SUB_OFF  = 3'h1;
  localparam logic [2:0] SUB_STOP = 3'h2;
  localparam logic [2:0] SUB_HALT = 3'h3;
  localparam logic [2:0] SUB_IDLE = 3'h4;
  localparam logic [3:0] FLD_CTL  = 4'hf;
  localparam logic [3:0] FLD_RET  = 4'he;
  localparam logic [3:0] OPD_NONE = 4'h0;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_PERMIT = 8'h00;
  localparam logic [7:0] OFS_PEND   = 8'h04;
  localparam logic [7:0] OFS_STATE  = 8'h08;
  localparam logic [7:0] OFS_EVT    = 8'h0c;
  localparam logic [7:0] OFS_MASK   = 8'h10;
  // ==========================================================
  // state register bits and event bits
  localparam int BIT_GIE    = 0;
  localparam int BIT_SHADOW = 1;
  localparam int BIT_HALT   = 2;
  localparam int BIT_STOP   = 3;
  localparam int EVT_ACPT   = 0;
  localparam int EVT_HALT   = 1;
  localparam int EVT_STOP   = 2;
  localparam int EVT_WAKE   = 3;
  localparam int EVTW       = 4;
  localparam logic [EVTW-1:0] RST_EVT  = 4'h0;
  localparam logic [EVTW-1:0] RST_MASK = 4'h0;
  localparam logic            RST_GIE  = 1'b0;
  localparam logic [15:0]     VEC_BASE = 16'h0001;
  // ==========================================================
  typedef enum logic [3:0] {
    ST_RUN  = 4'b0001,
    ST_ACPT = 4'b0010,
    ST_HALT = 4'b0100,
    ST_STOP = 4'b1000
  } isic_state_t;
  // ==========================================================
  function automatic logic is_sys(input logic [15:0] ins,
                                  input logic [2:0]  sub,
                                  input logic [3:0]  fld,
                                  input logic        any_opd);
    is_sys = (ins[15:11] == GRP_SYS) && (ins[10:8] == sub) &&
             (ins[7:4] == fld) && (any_opd || ins[3:0] == OPD_NONE);
  endfunction : is_sys
endpackage : isic_pkg
`default_nettype wire

//--- hw/isic_src_flags.sv
// per-source pending flags and lowest-index permitted pick
`default_nettype none
module isic_src_flags
  import isic_pkg::*;
#(
  parameter int NSRC = 4
) (
  input  wire logic            i_mclk,
  input  wire logic            i_rst_n,
  input  wire logic [NSRC-1:0] i_src_req,
  input  wire logic [NSRC-1:0] i_permit,
  input  wire logic            i_take,
  output logic [NSRC-1:0]      o_pend,
  output logic                 o_any,
  output logic [NSRC-1:0]      o_pick
);
  logic [NSRC-1:0] ready;
  assign ready = o_pend & i_permit;
  assign o_any = |ready;
  // ==========================================================
  // lowest index wins
  always_comb begin
    o_pick = '0;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (ready[k]) begin
        o_pick    = '0;
        o_pick[k] = 1'b1;
      end
    end
  end
  // ==========================================================
  // request latched regardless of permit
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_pend <= '0;
    end else begin
      // a new request beats the clear of acceptance
      o_pend <= (o_pend & ~(i_take ? o_pick : '0)) | i_src_req;
    end
  end
endmodule : isic_src_flags
`default_nettype wire

//--- hw/isic_ctx_stack.sv
// last-in first-out store of system state saved at acceptance
`default_nettype none
module isic_ctx_stack
  import isic_pkg::*;
#(
  parameter int SYSW  = 4,
  parameter int DEPTH = 8
) (
  input  wire logic            i_mclk,
  input  wire logic            i_rst_n,
  input  wire logic            i_push,
  input  wire logic            i_pop,
  input  wire logic [SYSW-1:0] i_data,
  output logic [SYSW-1:0]      o_data
);
  localparam int AW = $clog2(DEPTH + 1);
  logic [SYSW-1:0] mem [DEPTH];
  logic [AW-1:0]   cnt;
  // ==========================================================
  // overflow drops the oldest-free slot write; underflow reads 0
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt    <= '0;
      o_data <= '0;
    end else if (i_push && cnt < AW'(DEPTH)) begin
      mem[cnt[$clog2(DEPTH)-1:0]] <= i_data;
      cnt <= cnt + AW'(1);
    end else if (i_pop) begin
      if (cnt != '0) begin
        o_data <= mem[cnt[$clog2(DEPTH)-1:0] - 1'b1];
        cnt    <= cnt - AW'(1);
      end else begin
        o_data <= '0;
      end
    end
  end
endmodule : isic_ctx_stack
`default_nettype wire

//--- verification/isic_ctrl_properties.sv
// bound checker of the interrupt and standby control ports
`default_nettype none
module isic_ctrl_properties
  import isic_pkg::*;
#(
  parameter int          NSRC  = 4,
  parameter logic [15:0] VBASE = VEC_BASE
) (
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire logic        i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic [15:0] i_stack_top,
  input wire logic [3:0]  i_wake,
  input wire logic        o_hold,
  input wire logic        o_pc_load,
  input wire logic [15:0] o_pc_addr,
  input wire logic        o_pc_inc,
  input wire logic        o_sp_dec,
  input wire logic        o_sp_inc,
  input wire logic        o_stack_wr,
  input wire logic        o_sys_restore,
  input wire logic        o_osc_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // decode
  wire logic on_w   = i_instr_valid && i_instr == {GRP_SYS, SUB_ON, FLD_CTL, OPD_NONE};
  wire logic off_w  = i_instr_valid && i_instr == {GRP_SYS, SUB_OFF, FLD_CTL, OPD_NONE};
  wire logic idle_w = i_instr_valid && i_instr == {GRP_SYS, SUB_IDLE, FLD_CTL, OPD_NONE};
  wire logic ret_w  = i_instr_valid && i_instr == {GRP_SYS, SUB_IDLE, FLD_RET, OPD_NONE};
  wire logic stop_w = i_instr_valid && i_instr[15:4] == {GRP_SYS, SUB_STOP, FLD_CTL};
  wire logic halt_w = i_instr_valid && i_instr[15:4] == {GRP_SYS, SUB_HALT, FLD_CTL};
  logic       seen_on;
  logic [3:0] opd;
  // the release operand is only visible in the issuing cycle, so keep it
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      seen_on <= 1'b0;
      opd     <= 4'h0;
    end else begin
      if (on_w) begin
        seen_on <= 1'b1;
      end
      if (stop_w || halt_w) begin
        opd <= i_instr[3:0];
      end
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  enable_gap_a: assert property (on_w |=> !o_hold && !o_sp_dec ##1 !o_sp_dec)
    else $error("acceptance too soon after enable");
  off_blocks_a: assert property (off_w |=> !o_sp_dec [*3])
    else $error("acceptance after disable");
  first_on_a: assert property (o_sp_dec |-> seen_on)
    else $error("acceptance before any enable");
  vector_push_a: assert property (o_sp_dec |-> o_stack_wr && o_pc_load && o_hold &&
    o_pc_addr >= VBASE && o_pc_addr < VBASE + 16'(NSRC))
    else $error("bad acceptance strobes or vector");
  // hold may rise here for an acceptance that the enable delay held back
  idle_step_a: assert property (idle_w |=> o_pc_inc && !o_pc_load && !o_sp_dec && !o_sp_inc &&
    !o_stack_wr && !o_sys_restore)
    else $error("idle instruction did more than advance");
  ret_restore_a: assert property (ret_w |=> o_pc_load && o_sp_inc && o_sys_restore &&
    o_pc_addr == $past(i_stack_top))
    else $error("return did not restore");
  stop_osc_a: assert property (stop_w |=> !o_osc_en && o_hold)
    else $error("clock stop not entered");
  halt_hold_a: assert property (halt_w |=> o_hold && o_osc_en)
    else $error("halt not entered");
  stop_stays_a: assert property (!o_osc_en && (i_wake & opd) == 4'h0 |=> !o_osc_en)
    else $error("clock stop left without its condition");
  stop_wake_a: assert property (!o_osc_en && (i_wake & opd) != 4'h0 |=> o_osc_en)
    else $error("clock stop not released");
  cover property (o_sp_dec);
  cover property ($rose(o_osc_en));
  cover property (o_sys_restore);
endmodule : isic_ctrl_properties

bind isic_ctrl isic_ctrl_properties #(.NSRC(NSRC), .VBASE(VBASE)) u_props (
  .i_mclk, .i_rst_n, .i_instr_valid, .i_instr, .i_stack_top, .i_wake, .o_hold,
  .o_pc_load, .o_pc_addr, .o_pc_inc, .o_sp_dec, .o_sp_inc, .o_stack_wr, .o_sys_restore,
  .o_osc_en);
`default_nettype wire

//--- verification/isic_src_model.sv
// on-chip request sources facing the control block
`default_nettype none
module isic_src_model (
  input  wire logic     i_mclk,
  output var logic [3:0] o_src_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_src_req = 4'h0;
  // fire ignoring permit
  // a source raises its request whatever its permit flag holds
  task automatic fire(input logic [3:0] m);
    @(posedge i_mclk);
    o_src_req <= m;
    @(posedge i_mclk);
    o_src_req <= 4'h0;
  endtask : fire
endmodule : isic_src_model
`default_nettype wire

//--- verification/isic_ctrl_tb.sv
// self-checking bench for the interrupt and standby control block
`default_nettype none
module isic_ctrl_tb
  import isic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] VB     = 16'h0020;
  localparam logic [15:0] W_ON   = {GRP_SYS, SUB_ON, FLD_CTL, OPD_NONE};
  localparam logic [15:0] W_OFF  = {GRP_SYS, SUB_OFF, FLD_CTL, OPD_NONE};
  localparam logic [15:0] W_IDLE = {GRP_SYS, SUB_IDLE, FLD_CTL, OPD_NONE};
  localparam logic [15:0] W_RET  = {GRP_SYS, SUB_IDLE, FLD_RET, OPD_NONE};
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        ivalid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [15:0] ret_addr = 16'h0123;
  logic [15:0] stack_top = 16'h0abc;
  logic [3:0]  sys_state = 4'ha;
  logic [3:0]  wake = 4'h0;
  logic [3:0]  src_req;
  logic [31:0] prdata, q;
  logic [15:0] pc_addr, stack_wdata, got_pc, got_wd, w;
  logic [3:0]  sys_data;
  logic        pready, pslverr, hold, pc_load, pc_inc, sp_dec, sp_inc, stack_wr;
  logic        sys_restore, osc_en, irq, e;
  int          num_errors = 0;
  int          n_tests = 0;
  int          at;
  always #5 mclk = ~mclk;
  isic_src_model u_src (.i_mclk(mclk), .o_src_req(src_req));
  isic_ctrl #(.NSRC(4), .SYSW(4), .DEPTH(8), .VBASE(VB)) dut (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_instr_valid(ivalid), .i_instr(instr),
    .i_ret_addr(ret_addr), .i_stack_top(stack_top), .i_sys_state(sys_state),
    .i_src_req(src_req), .i_wake(wake), .o_hold(hold), .o_pc_load(pc_load),
    .o_pc_addr(pc_addr), .o_pc_inc(pc_inc), .o_sp_dec(sp_dec), .o_sp_inc(sp_inc),
    .o_stack_wr(stack_wr), .o_stack_wdata(stack_wdata), .o_sys_restore(sys_restore),
    .o_sys_data(sys_data), .o_osc_en(osc_en), .o_irq(irq));
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  // the second word follows with no gap, as the enable delay is about that case
  task automatic op2(input logic [15:0] w0, input logic [15:0] w1, input logic two);
    @(posedge mclk);
    ivalid <= 1'b1;
    instr  <= w0;
    if (two) begin
      @(posedge mclk);
      instr <= w1;
    end
    @(posedge mclk);
    ivalid <= 1'b0;
    @(negedge mclk);
  endtask : op2
  task automatic watch(input int n);
    at = 0;
    for (int i = 1; i <= n; i++) begin
      @(negedge mclk);
      if (sp_dec === 1'b1 && at == 0) begin
        at     = i;
        got_pc = pc_addr;
        got_wd = stack_wdata;
      end
    end
  endtask : watch
  task automatic wake_to(input logic [3:0] v);
    @(posedge mclk);
    wake <= v;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask : wake_to
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  // the whole sequence needs about a hundred cycles; this leaves ample margin
  initial begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    conclude();
  end
  // ==========================================================
  // tests
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(OFS_STATE, 32'h0);
    rd(OFS_PERMIT, 32'h0);
    rd(OFS_MASK, 32'h0);
    chk(osc_en, 1'b1);
    rd(8'h20, 32'h0);
    chk(e, 1'b1);
    u_src.fire(4'h4);
    op2(W_ON, W_IDLE, 1'b1);
    chk(pc_inc, 1'b1);
    watch(8);
    chk(at, 0);
    rd(OFS_PEND, 32'h4);
    rd(OFS_STATE, 32'h1);
    apb(1'b1, OFS_PERMIT, 32'hf);
    watch(4);
    chk(at, 2);
    chk(got_pc, VB + 16'h2);
    chk(got_wd, 16'h0123);
    rd(OFS_PEND, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, OFS_MASK, 32'hf);
    repeat (2) @(negedge mclk);
    chk(irq, 1'b1);
    rd(OFS_EVT, 32'h1);
    repeat (2) @(negedge mclk);
    chk(irq, 1'b0);
    @(posedge mclk);
    sys_state <= 4'h5;
    ret_addr  <= 16'h0456;
    u_src.fire(4'h3);
    op2(W_ON, W_OFF, 1'b1);
    watch(8);
    chk(at, 0);
    op2(W_ON, W_IDLE, 1'b1);
    watch(8);
    chk(at, 1);
    chk(got_pc, VB);
    chk(got_wd, 16'h0456);
    rd(OFS_PEND, 32'h2);
    op2(W_RET, W_RET, 1'b0);
    chk(pc_addr, 16'h0abc);
    chk(sys_restore, 1'b1);
    chk(sp_inc, 1'b1);
    chk(sys_data, 4'h5);
    op2(W_RET, W_RET, 1'b0);
    chk(sys_data, 4'ha);
    for (int k = 0; k < 2; k++) begin
      w = (k == 1) ? {GRP_SYS, SUB_STOP, FLD_CTL, 4'h8} : {GRP_SYS, SUB_HALT, FLD_CTL, 4'h2};
      op2(w, w, 1'b0);
      chk(hold, 1'b1);
      chk(osc_en, k == 0);
      wake_to(~w[3:0]);
      chk(hold, 1'b1);
      chk(osc_en, k == 0);
      wake_to(w[3:0]);
      chk(hold, 1'b0);
      chk(osc_en, 1'b1);
    end
    rd(OFS_EVT, 32'hf);
    conclude();
  end
endmodule : isic_ctrl_tb
`default_nettype wire
